//--- design/ssi_pkg.sv
// package for the synchronous serial port (spi master/slave, i2c slave)
// assumes a 40 MHz ref_clk and an avalon-mm master with 32-bit data
package ssi_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_EVENT_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_DATA_BUFFER   = 8'h13;
  localparam logic [7:0] IDX_PORT_CONTROL  = 8'h14;
  localparam logic [7:0] IDX_EVENT_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_OWN_ADDRESS   = 8'h93;
  localparam logic [7:0] IDX_PORT_STATUS   = 8'h94;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_WRITE_COLLISION_FLAG   = 7;
  localparam int CTL_OV     = 6;
  localparam int CTL_EN     = 5;
  localparam int CTL_CKP    = 4;
  localparam int STAT_SMP   = 7;
  localparam int STAT_CKE   = 6;
  localparam int STAT_DA    = 5;
  localparam int STAT_P     = 4;
  localparam int STAT_S     = 3;
  localparam int STAT_RW    = 2;
  localparam int STAT_UA    = 1;
  localparam int STAT_BF    = 0;
  localparam int EVENT_BIT  = 3;
  localparam int DIR_SDA    = 4;
  localparam int DIR_SCL    = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] CTL_RST      = 8'h00;
  localparam logic [7:0] STAT_RST     = 8'h00;
  localparam logic [7:0] ENABLES_RST  = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;

  // ************************************************************
  // mode codes and clock dividers
  // ************************************************************
  localparam logic [3:0] MODE_SPI_DIV4  = 4'h0;
  localparam logic [3:0] MODE_SPI_DIV16 = 4'h1;
  localparam logic [3:0] MODE_SPI_DIV64 = 4'h2;
  localparam logic [3:0] MODE_SPI_TMR   = 4'h3;
  localparam logic [3:0] MODE_SLV_SS    = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS  = 4'h5;
  localparam logic [3:0] MODE_I2C_7     = 4'h6;
  localparam logic [3:0] MODE_I2C_10    = 4'h7;
  localparam logic [3:0] MODE_I2C_FWM   = 4'hB;
  localparam logic [3:0] MODE_I2C_7SP   = 4'hE;
  localparam logic [3:0] MODE_I2C_10SP  = 4'hF;
  localparam logic [6:0] SCK_DIV_4      = 7'h04;
  localparam logic [6:0] SCK_DIV_16     = 7'h10;
  localparam logic [6:0] SCK_DIV_64     = 7'h40;
  localparam logic [4:0] ADDR10_PATTERN = 5'h1E;
  localparam logic [3:0] BITS_PER_WORD  = 4'h8;

  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TACK} ssi_i2c_st_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ssi_avm_req_t;

  typedef struct packed {
    logic sck;
    logic serial_data_in;
    logic ss_n;
  } ssi_pin_in_t;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic sda;
    logic sda_oe_n;
    logic serial_data_out;
    logic sdo_oe_n;
  } ssi_pin_out_t;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  stat;
    logic        ev_flag;
    logic [7:0]  ev_en;
    logic [7:0]  dbuf;
    logic [7:0]  own_addr;
    logic [7:0]  sr;
    logic [7:0]  rx;
    logic [3:0]  cnt;
    logic [5:0]  div;
    logic        busy;
    logic        sck;
    logic        sck_q;
    logic        sda_q;
    ssi_i2c_st_t st;
    logic        addressed;
    logic        second10;
    logic        matched10;
    logic        ack_slot;
    logic        bus_ack;
    logic [31:0] rdata;
  } ssi_state_t;

endpackage : ssi_pkg

//--- design/ssi_port.sv
// synchronous serial port: spi master/slave and i2c slave with register file
// assumes avalon-mm master, synchronous pin inputs, outside pad logic for oe
// Notes on behaviour
// - spi idle clock level follows clock polarity bit.
// - i2c with clock polarity clear holds scl low.
// - master codes 0-2 divide clock by 4,16,64; code 3 uses timer/2.
// - code 4 slave with select pin, code 5 slave ignoring select.
// - i2c codes 6,7 slaves, B firmware master, E,F slaves with start/stop events.
// - spi shifts eight bits out and in together.
// - slave with select control resets while select is high.
// - i2c slave with 7/10-bit addressing and start/stop events.
// - i2c pins are open drain when enabled and set as inputs.
// - scl/sda inputs, overridden by slave transmit data.
// - match or data byte loads the buffer, then gets automatic ack.
// - full blocks load and ack; overflow alone loads without ack; event always.
// - buffer read clears full flag; overflow stays until software clears.
// - after start, eight bits shift in on scl rising edges.
// - shift bits 7..1 compared with own address at eighth falling edge.
// - match loads buffer, sets full, acks; event at ninth falling edge.
// - 10-bit first byte is 11110, two high bits, write.
// - 10-bit address bytes set update flag and hold scl until address write.
// - buffer write during transmission sets sticky collision flag.
// - edge select with polarity picks the sck edge that changes data.
// - master sample phase picks end or middle of the output time.
// - spi overflow only in slave mode; the new byte is lost.
module ssi_port (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire ssi_pkg::ssi_avm_req_t avm_req,
  output      logic [31:0]           avm_readdata,
  output      logic                  avm_waitrequest,
  input  wire ssi_pkg::ssi_pin_in_t  pin_in,
  output      ssi_pkg::ssi_pin_out_t pin_out,
  input  wire logic                  second_timer_output,
  input  wire logic [7:0]            port_c_direction
);
  import ssi_pkg::*;

  ssi_state_t q;
  ssi_state_t n;

  logic       req, acc, wr_lo, rd, buf_wr;
  logic [7:0] wdat, rmux, rxf;
  logic [3:0] mode, cnt_nx;
  logic       en, clock_polarity_ctl, cke, input_sample_phase, is_master, is_slave, is_i2c, pins_ok, sp_int;
  logic       tick, lead, trail, chg, samp, done, free, match, ten;
  logic       start, stop, rise, fall;

  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : hit

  function automatic logic [5:0] half_period(input logic [3:0] m);
    logic [6:0] d;
    d = (m == MODE_SPI_DIV16) ? SCK_DIV_16 : (m == MODE_SPI_DIV64) ? SCK_DIV_64 : SCK_DIV_4;
    half_period = d[6:1] - 6'h01;
  endfunction : half_period

  // ************************************************************
  // decode of current mode
  // ************************************************************
  assign mode      = q.ctl[3:0];
  assign en        = q.ctl[CTL_EN];
  assign clock_polarity_ctl       = q.ctl[CTL_CKP];
  assign cke       = q.stat[STAT_CKE];
  assign input_sample_phase       = q.stat[STAT_SMP];
  assign is_master = en & (mode <= MODE_SPI_TMR);
  assign is_slave  = en & ((mode == MODE_SLV_SS) | (mode == MODE_SLV_NOSS));
  assign is_i2c    = en & ((mode == MODE_I2C_7) | (mode == MODE_I2C_10) | (mode == MODE_I2C_FWM)
                     | (mode == MODE_I2C_7SP) | (mode == MODE_I2C_10SP));
  assign sp_int    = (mode == MODE_I2C_FWM) | (mode == MODE_I2C_7SP) | (mode == MODE_I2C_10SP);
  assign pins_ok   = port_c_direction[DIR_SDA] & port_c_direction[DIR_SCL];
  assign req       = avm_req.read | avm_req.write;

  // ************************************************************
  // pins and bus answer
  // ************************************************************
  // open drain on the i2c pins: the pad only pulls low there, release means sck_oe_n and sda_oe_n high
  always_comb begin
    pin_out.sck      = is_i2c ? 1'b0 : q.sck;
    pin_out.sck_oe_n = ~(is_master | (is_i2c & pins_ok & (~clock_polarity_ctl | q.stat[STAT_UA])));
    pin_out.sda      = 1'b0;
    pin_out.sda_oe_n = ~(is_i2c & pins_ok & (((q.st == I2C_ACK) & q.ack_slot)
                       | ((q.st == I2C_TX) & ~q.sr[7])));
    pin_out.serial_data_out      = q.sr[7];
    pin_out.sdo_oe_n = ~((is_master | is_slave) & ~((mode == MODE_SLV_SS) & pin_in.ss_n));
  end
  assign avm_readdata    = q.rdata;
  assign avm_waitrequest = req & ~q.bus_ack;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n      = q;
    acc    = req & q.bus_ack;
    wdat   = avm_req.writedata[7:0];
    wr_lo  = acc & avm_req.write & avm_req.byteenable[0];
    rd     = acc & avm_req.read;
    buf_wr = wr_lo & hit(avm_req.address, IDX_DATA_BUFFER);
    rmux   = 8'h00;
    rxf    = 8'h00;
    cnt_nx = q.cnt;
    tick   = 1'b0;
    lead   = 1'b0;
    trail  = 1'b0;
    chg    = 1'b0;
    samp   = 1'b0;
    done   = 1'b0;
    free   = ~q.stat[STAT_BF] & ~q.ctl[CTL_OV];
    match  = 1'b0;
    ten    = mode[0];
    rise   = ~q.sck_q & pin_in.sck;
    fall   = q.sck_q & ~pin_in.sck;
    start  = q.sck_q & pin_in.sck & q.sda_q & ~pin_in.serial_data_in;
    stop   = q.sck_q & pin_in.sck & ~q.sda_q & pin_in.serial_data_in;
    n.sck_q = pin_in.sck;
    n.sda_q = pin_in.serial_data_in;

    // one wait state: data is prepared while waitrequest is high
    n.bus_ack = req & ~q.bus_ack;
    if (hit(avm_req.address, IDX_EVENT_FLAGS))   rmux[EVENT_BIT] = q.ev_flag;
    if (hit(avm_req.address, IDX_DATA_BUFFER))   rmux = q.dbuf;
    if (hit(avm_req.address, IDX_PORT_CONTROL))  rmux = q.ctl;
    if (hit(avm_req.address, IDX_EVENT_ENABLES)) rmux = q.ev_en;
    if (hit(avm_req.address, IDX_OWN_ADDRESS))   rmux = q.own_addr;
    if (hit(avm_req.address, IDX_PORT_STATUS))   rmux = q.stat;
    if (avm_req.read & ~q.bus_ack) begin
      n.rdata = {24'h000000, rmux};
    end

    // software side; hardware sets below override a clear in the same cycle
    if (wr_lo & hit(avm_req.address, IDX_PORT_CONTROL)) n.ctl = wdat;
    if (wr_lo & hit(avm_req.address, IDX_PORT_STATUS)) n.stat[7:6] = wdat[7:6];
    if (wr_lo & hit(avm_req.address, IDX_EVENT_FLAGS)) n.ev_flag = wdat[EVENT_BIT];
    if (wr_lo & hit(avm_req.address, IDX_EVENT_ENABLES)) n.ev_en = wdat;
    if (wr_lo & hit(avm_req.address, IDX_OWN_ADDRESS)) begin
      n.own_addr      = wdat;
      n.stat[STAT_UA] = 1'b0;
    end
    if (rd & hit(avm_req.address, IDX_DATA_BUFFER)) n.stat[STAT_BF] = 1'b0;

    if (!en) begin
      n.busy      = 1'b0;
      n.cnt       = 4'h0;
      n.sck       = n.ctl[CTL_CKP];
      n.st        = I2C_IDLE;
      n.addressed = 1'b0;
      n.second10  = 1'b0;
      n.matched10 = 1'b0;
      n.ack_slot  = 1'b0;
      n.stat[STAT_S] = 1'b0;
      n.stat[STAT_P] = 1'b0;
      if (buf_wr) n.dbuf = wdat;
    end else if (is_master | is_slave) begin
      // ******** spi engine ********
      if (is_master) begin
        tick = (mode == MODE_SPI_TMR) ? second_timer_output : (q.div == half_period(mode));
        if (q.busy) begin
          n.div = tick ? 6'h00 : q.div + 6'h01;
          if (tick) begin
            n.sck = ~q.sck;
            lead  = (q.sck == clock_polarity_ctl);
            trail = ~lead;
          end
        end else begin
          // idle level follows a polarity write in the same cycle
          n.sck = n.ctl[CTL_CKP];
        end
      end else begin
        lead  = (pin_in.sck != q.sck_q) & (q.sck_q == clock_polarity_ctl);
        trail = (pin_in.sck != q.sck_q) & (q.sck_q != clock_polarity_ctl);
      end
      chg  = cke ? lead : trail;
      samp = (is_master & input_sample_phase) ? chg : (cke ? trail : lead);
      if (samp) begin
        n.rx   = {q.rx[6:0], pin_in.serial_data_in};
        cnt_nx = q.cnt + 4'h1;
        n.cnt  = cnt_nx;
      end
      // leading-edge output: bit 7 is already on the pin, first edge keeps it
      if (chg & (~cke | (q.cnt != 4'h0))) n.sr = {q.sr[6:0], 1'b0};
      done = trail & (cnt_nx == BITS_PER_WORD);
      if (done) begin
        rxf     = n.rx;
        n.busy  = 1'b0;
        n.cnt   = 4'h0;
        n.ev_flag = 1'b1;
        if (is_master | ~q.stat[STAT_BF]) begin
          n.dbuf          = rxf;
          n.stat[STAT_BF] = 1'b1;
        end else begin
          n.ctl[CTL_OV] = 1'b1;
        end
      end
      if (buf_wr) begin
        if (q.busy | (is_slave & (q.cnt != 4'h0))) begin
          n.ctl[CTL_WRITE_COLLISION_FLAG] = 1'b1;
        end else begin
          n.sr   = wdat;
          n.dbuf = wdat;
          n.busy = is_master;
          n.cnt  = 4'h0;
          n.div  = 6'h00;
        end
      end
      if ((mode == MODE_SLV_SS) & pin_in.ss_n) begin
        n.cnt = 4'h0;
        n.rx  = 8'h00;
      end
    end else if (is_i2c) begin
      // ******** i2c slave engine ********
      if (buf_wr) begin
        if ((q.st == I2C_TX) & (q.cnt != 4'h0)) begin
          n.ctl[CTL_WRITE_COLLISION_FLAG] = 1'b1;
        end else begin
          n.dbuf = wdat;
          if (q.st == I2C_TX) begin
            n.sr            = wdat;
            n.stat[STAT_BF] = 1'b1;
          end
        end
      end
      if (start) begin
        n.stat[STAT_S] = 1'b1;
        n.stat[STAT_P] = 1'b0;
        n.st           = (mode == MODE_I2C_FWM) ? I2C_IDLE : I2C_RX;
        n.cnt          = 4'h0;
        n.addressed    = 1'b0;
        n.ack_slot     = 1'b0;
        if (sp_int) n.ev_flag = 1'b1;
      end else if (stop) begin
        n.stat[STAT_P] = 1'b1;
        n.stat[STAT_S] = 1'b0;
        n.st           = I2C_IDLE;
        n.addressed    = 1'b0;
        n.second10     = 1'b0;
        n.matched10    = 1'b0;
        n.ack_slot     = 1'b0;
        if (sp_int) n.ev_flag = 1'b1;
      end else begin
        unique case (q.st)
          I2C_IDLE: begin
          end
          I2C_RX: begin
            if (rise) begin
              n.sr  = {q.sr[6:0], pin_in.serial_data_in};
              n.cnt = q.cnt + 4'h1;
            end
            if (fall & (q.cnt == BITS_PER_WORD)) begin
              if (q.addressed) begin
                match          = 1'b1;
                n.stat[STAT_DA] = 1'b1;
              end else if (ten & q.second10) begin
                match = (q.sr == q.own_addr);
              end else begin
                match = (q.sr[7:1] == q.own_addr[7:1])
                        & (~ten | (q.sr[7:3] == ADDR10_PATTERN));
              end
              if (match & ~q.addressed) begin
                n.stat[STAT_DA] = 1'b0;
                if (~ten | q.matched10) begin
                  n.addressed    = 1'b1;
                  n.stat[STAT_RW] = q.sr[0];
                end else if (~q.second10) begin
                  n.second10      = 1'b1;
                  n.stat[STAT_UA] = 1'b1;
                  n.stat[STAT_RW] = q.sr[0];
                end else begin
                  n.second10      = 1'b0;
                  n.matched10     = 1'b1;
                  n.addressed     = 1'b1;
                  n.stat[STAT_UA] = 1'b1;
                end
              end
              if (match) begin
                n.st       = I2C_ACK;
                n.ack_slot = free;
                if (~q.stat[STAT_BF]) begin
                  n.dbuf          = q.sr;
                  n.stat[STAT_BF] = 1'b1;
                end else begin
                  n.ctl[CTL_OV] = 1'b1;
                end
              end else begin
                n.st = I2C_IDLE;
              end
            end
          end
          I2C_ACK: begin
            if (fall) begin
              n.ev_flag  = 1'b1;
              n.ack_slot = 1'b0;
              n.cnt      = 4'h0;
              if (q.addressed & q.stat[STAT_RW]) begin
                n.st          = I2C_TX;
                n.ctl[CTL_CKP] = 1'b0;
              end else begin
                n.st = I2C_RX;
              end
            end
          end
          I2C_TX: begin
            if (fall) begin
              n.sr  = {q.sr[6:0], 1'b1};
              n.cnt = q.cnt + 4'h1;
              if (q.cnt == (BITS_PER_WORD - 4'h1)) begin
                n.st            = I2C_TACK;
                n.stat[STAT_BF] = 1'b0;
              end
            end
          end
          I2C_TACK: begin
            if (rise & pin_in.serial_data_in) begin
              n.st            = I2C_IDLE;
              n.addressed     = 1'b0;
              n.stat[STAT_RW] = 1'b0;
              n.stat[STAT_DA] = 1'b0;
            end else if (rise) begin
              n.ack_slot = 1'b1;
            end
            if (fall & q.ack_slot) begin
              n.ev_flag      = 1'b1;
              n.ack_slot     = 1'b0;
              n.cnt          = 4'h0;
              n.st           = I2C_TX;
              n.ctl[CTL_CKP] = 1'b0;
            end
          end
        endcase
      end
    end else if (buf_wr) begin
      n.dbuf = wdat;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q          <= '0;
      q.ctl      <= CTL_RST;
      q.stat     <= STAT_RST;
      q.ev_en    <= ENABLES_RST;
      q.own_addr <= OWN_ADDR_RST;
      q.st       <= I2C_IDLE;
    end else begin
      q <= n;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_spi_idle_level: assert property (@(posedge ref_clk) disable iff (rst)
    (is_master & ~q.busy) |-> (pin_out.sck == clock_polarity_ctl))
    else $error("spi master clock not at idle level");
  a_i2c_clock_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (is_i2c & pins_ok & ~clock_polarity_ctl) |-> (~pin_out.sck_oe_n & ~pin_out.sck))
    else $error("i2c clock not held low");
  a_div4_half_period: assert property (@(posedge ref_clk) disable iff (rst)
    (is_master & (mode == MODE_SPI_DIV4) & q.busy & $changed(q.sck) & $stable(q.ctl))
      |=> (!$changed(q.sck) ##1 ($changed(q.sck) || !q.busy)))
    else $error("fosc/4 clock half period wrong");
  a_select_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (en & (mode == MODE_SLV_SS) & pin_in.ss_n) |=> (q.cnt == 4'h0))
    else $error("slave not reset by select");
  a_buf_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (rd & hit(avm_req.address, IDX_DATA_BUFFER) & ~done & (q.st != I2C_RX) & ~buf_wr)
      |=> !q.stat[STAT_BF])
    else $error("buffer read did not clear full flag");
  a_ack_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (is_i2c & pins_ok & (q.st == I2C_ACK) & q.ack_slot) |-> !pin_out.sda_oe_n)
    else $error("ack not driven");
  a_no_ack_full: assert property (@(posedge ref_clk) disable iff (rst)
    (is_i2c & (q.st == I2C_RX) & fall & (q.cnt == BITS_PER_WORD) & q.stat[STAT_BF])
      |=> (!q.ack_slot && $stable(q.dbuf)))
    else $error("full buffer was loaded or acked");
  a_collision_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (buf_wr & is_master & q.busy) |=> (q.ctl[CTL_WRITE_COLLISION_FLAG] && $stable(q.sr)))
    else $error("collision not flagged");
  a_master_no_ovf: assert property (@(posedge ref_clk) disable iff (rst)
    (is_master & !(wr_lo & hit(avm_req.address, IDX_PORT_CONTROL)))
      |=> !$rose(q.ctl[CTL_OV]))
    else $error("overflow set in master mode");
  a_start_event: assert property (@(posedge ref_clk) disable iff (rst)
    (is_i2c & sp_int & start) |=> (q.ev_flag && q.stat[STAT_S] && !q.stat[STAT_P]))
    else $error("start event missing");

endmodule : ssi_port

//--- verif/ssi_spi_peer.sv
// far-side spi slave: shifts a byte in and out while the port is master
// assumes sck and mosi settle on ref_clk, data sampled on rising sck
module ssi_spi_peer (
  input  wire logic       ref_clk,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output      logic       miso,
  output      logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sck_q = 1'b0;
  logic [7:0] sh    = 8'h00;
  // shifted-in filler is inverted so stale bits never look valid
  always @(posedge ref_clk) begin
    sck_q <= sck;
    if (load) begin
      sh <= tx_byte;
    end else if (sck && !sck_q) begin
      rx_byte <= {rx_byte[6:0], mosi};
    end else if (!sck && sck_q) begin
      sh <= {sh[6:0], ~sh[0]};
    end
  end
  assign miso = sh[7];
endmodule : ssi_spi_peer

//--- verif/sync_serial_port_spi_i2c_slave_bench.sv
// bench: registers over avalon-mm, spi master traffic, slave select
// assumes ssi_pkg, ssi_port and ssi_spi_peer compiled before it
module sync_serial_port_spi_i2c_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ssi_pkg::*;
  // ************
  // harness
  // ************
  logic         ref_clk  = 1'b0;
  logic         rst      = 1'b1;
  logic         ss_n     = 1'b1;
  logic         tick     = 1'b0;
  logic         p_load   = 1'b0;
  logic         sq       = 1'b0;
  logic         i2c      = 1'b0;
  logic         scl_m    = 1'b1;
  logic         sda_m    = 1'b1;
  logic [7:0]   dir      = 8'h18;
  logic         miso;
  logic         wreq;
  logic [31:0]  rdata;
  logic [31:0]  seed     = 32'h00000010;
  logic [7:0]   p_tx     = 8'h00;
  logic [7:0]   p_rx, rv, tx, ptx;
  logic [7:0]   last_run = 8'h00;
  logic [7:0]   run      = 8'h00;
  logic [7:0]   regs [6];
  int           errors   = 0;
  int           cmp_count = 0;
  int           cyc      = 0;
  ssi_avm_req_t avm_req  = '0;
  ssi_pin_in_t  pin_in;
  ssi_pin_out_t pin_out;
  always #12.5 ref_clk = ~ref_clk;
  // i2c lines are wired-and with pull-ups: either side may pull low
  assign pin_in = i2c ? {scl_m & pin_out.sck_oe_n, sda_m & pin_out.sda_oe_n, ss_n}
                      : {(pin_out.sck_oe_n ? 1'b0 : pin_out.sck), miso, ss_n};
  ssi_port u_dut (.ref_clk(ref_clk), .rst(rst), .avm_req(avm_req), .avm_readdata(rdata),
    .avm_waitrequest(wreq), .pin_in(pin_in), .pin_out(pin_out),
    .second_timer_output(tick), .port_c_direction(dir));
  ssi_spi_peer u_peer (.ref_clk(ref_clk), .sck(pin_out.sck), .mosi(pin_out.serial_data_out),
    .load(p_load), .tx_byte(p_tx), .miso(miso), .rx_byte(p_rx));
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // run length of sck levels gives the half period
  always @(posedge ref_clk) begin
    cyc++;
    tick <= (cyc[2:0] == 3'h0);
    sq <= pin_out.sck;
    if (pin_out.sck !== sq) begin
      last_run <= run;
      run <= 8'h01;
    end else run <= run + 8'h01;
    if (cyc == 40000) begin
      errors++;
      complete_run;
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] half(input int m);
    return (m == 0) ? 8'h02 : (m == 2) ? 8'h20 : 8'h08;
  endfunction : half
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd_v);
    int n;
    n = 0;
    avm_req.read <= ~w;
    avm_req.write <= w;
    avm_req.address <= {idx, 2'b00};
    avm_req.writedata <= {24'h000000, wd};
    avm_req.byteenable <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq && n < 20);
    rd_v = rdata[7:0];
    chk({7'h00, wreq}, 8'h00);
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, d);
  endtask : rd
  task automatic i2c_step(input logic c, input logic d);
    scl_m <= c;
    sda_m <= d;
    repeat (3) @(posedge ref_clk);
  endtask : i2c_step
  // ************
  // scenarios
  // ************
  initial begin
    regs = '{IDX_EVENT_FLAGS, IDX_PORT_CONTROL, IDX_EVENT_ENABLES, IDX_OWN_ADDRESS,
             IDX_PORT_STATUS, 8'h3F};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      rd(regs[i], rv);
      chk(rv, 8'h00);
    end
    tx = rnd();
    wr(IDX_EVENT_ENABLES, tx);
    rd(IDX_EVENT_ENABLES, rv);
    chk(rv, tx);
    wr(8'h3F, tx);
    rd(8'h3F, rv);
    chk(rv, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(IDX_PORT_CONTROL, 8'h00);
      wr(IDX_PORT_STATUS, 8'h00);
      wr(IDX_PORT_CONTROL, 8'h20 | m[7:0]);
      chk({7'h00, pin_out.sck}, 8'h00);
      ptx = rnd();
      tx = rnd();
      p_tx <= ptx;
      p_load <= 1'b1;
      @(posedge ref_clk);
      p_load <= 1'b0;
      wr(IDX_DATA_BUFFER, tx);
      wr(IDX_DATA_BUFFER, ~tx);
      rv = 8'h00;
      for (int k = 0; k < 300 && rv[3] !== 1'b1; k++) rd(IDX_EVENT_FLAGS, rv);
      chk(rv & 8'h08, 8'h08);
      rd(IDX_PORT_STATUS, rv);
      chk(rv & 8'h01, 8'h01);
      rd(IDX_DATA_BUFFER, rv);
      chk(rv, ptx);
      chk(p_rx, tx);
      rd(IDX_PORT_STATUS, rv);
      chk(rv & 8'h01, 8'h00);
      rd(IDX_PORT_CONTROL, rv);
      chk(rv & 8'h80, 8'h80);
      chk(last_run, half(m));
      wr(IDX_EVENT_FLAGS, 8'h00);
    end
    wr(IDX_PORT_CONTROL, 8'h30);
    chk({7'h00, pin_out.sck}, 8'h01);
    $display("test spi master done");
    for (int m = 4; m < 6; m++) begin
      wr(IDX_PORT_CONTROL, 8'h00);
      wr(IDX_PORT_CONTROL, 8'h20 | m[7:0]);
      ss_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk({7'h00, pin_out.sdo_oe_n}, (m == 4) ? 8'h01 : 8'h00);
      ss_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({7'h00, pin_out.sdo_oe_n}, 8'h00);
    end
    $display("test slave select done");
    tx = rnd() & 8'hFE;
    wr(IDX_PORT_CONTROL, 8'h00);
    i2c <= 1'b1;
    dir <= 8'h00;
    wr(IDX_OWN_ADDRESS, tx);
    wr(IDX_PORT_CONTROL, 8'h26);
    chk({7'h00, pin_out.sck_oe_n}, 8'h01);
    dir <= 8'h18;
    @(posedge ref_clk);
    chk({7'h00, pin_out.sck_oe_n}, 8'h00);
    wr(IDX_PORT_CONTROL, 8'h36);
    chk({7'h00, pin_out.sck_oe_n}, 8'h01);
    i2c_step(1'b1, 1'b0);
    for (int b = 7; b >= 0; b--) begin
      i2c_step(1'b0, tx[b]);
      i2c_step(1'b1, tx[b]);
    end
    i2c_step(1'b0, 1'b1);
    chk({7'h00, pin_out.sda_oe_n}, 8'h00);
    i2c_step(1'b1, 1'b1);
    i2c_step(1'b0, 1'b0);
    chk({7'h00, pin_out.sda_oe_n}, 8'h01);
    i2c_step(1'b1, 1'b0);
    i2c_step(1'b1, 1'b1);
    rd(IDX_EVENT_FLAGS, rv);
    chk(rv & 8'h08, 8'h08);
    rd(IDX_PORT_STATUS, rv);
    chk(rv & 8'h11, 8'h11);
    rd(IDX_DATA_BUFFER, rv);
    chk(rv, tx);
    $display("test i2c slave done");
    complete_run;
  end
endmodule : sync_serial_port_spi_i2c_slave_bench
